// >>> hw/fpcc_pkg.sv
// Shared constants and types for the fast pulse counter compare and rate unit
package fpcc_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RING = 8'h04;
    localparam logic [7:0] ADDR_PRESET = 8'h08;
    localparam logic [7:0] ADDR_LOW = 8'h0C;
    localparam logic [7:0] ADDR_HIGH = 8'h10;
    localparam logic [7:0] ADDR_REFRESH = 8'h14;
    localparam logic [7:0] ADDR_PPR = 8'h18;
    localparam logic [7:0] ADDR_COUNT = 8'h1C;
    localparam logic [7:0] ADDR_RATE = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int C_START = 0;
    localparam int C_RING = 1;
    localparam int C_CMP_EN = 2;
    localparam int C_ZONE = 3;
    localparam int C_TASK = 4;
    localparam int C_RATE_EN = 5;
    localparam int C_POINT = 6;
    localparam int C_PRIO = 9;
    localparam int C_EXT_PRE = 12;
    localparam int C_INT_PRE = 13;
    // Status field positions
    localparam int S_CARRY = 8;
    localparam int S_BORROW = 9;
    localparam int S_IRQ = 10;
    localparam int S_RATE_NEW = 11;
    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] RING_RST = 32'h0000_4E20;
    localparam logic [12:0] REFRESH_RST = 13'h0064;
    localparam logic [15:0] PPR_RST = 16'h003C;
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_RING = 8'h11;
    localparam logic [7:0] ERR_ZONE = 8'h12;
    localparam logic [7:0] ERR_BOTH = 8'h13;
    localparam logic [31:0] RING_MIN = 32'h0000_0002;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam logic [15:0] REFRESH_UNIT_MS = 16'h000A;
    localparam logic [47:0] RATE_SCALE = 48'h0000_0000_EA60;
    localparam logic [5:0] DIV_STEPS = 6'h30;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [31:0] fpcc_word_t;
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_DIV = 2'b01,
        RS_WRITE = 2'b11
    } fpcc_rate_st_t;
    typedef struct packed {
        logic [2:0] pulse_sy;
        logic [2:0] dir_sy;
        logic [2:0] pre_sy;
        logic pready;
        logic pslverr;
        fpcc_word_t prdata;
        fpcc_word_t ctrl;
        fpcc_word_t ring_set;
        fpcc_word_t preset;
        fpcc_word_t low;
        fpcc_word_t high;
        logic [12:0] refresh;
        logic [15:0] ppr;
        logic start_prev;
        logic int_pre_prev;
        logic running;
        logic ring_err;
        fpcc_word_t count;
        logic carry;
        logic borrow;
        logic eq_prev;
        logic irq_pend;
        logic irq;
        logic [2:0] prio;
        logic [7:0] outs;
        logic [17:0] ms_cnt;
        logic [15:0] ref_cnt;
        fpcc_word_t last;
        fpcc_rate_st_t rst;
        logic [47:0] num;
        logic [32:0] rem;
        logic [31:0] den;
        logic neg;
        logic [5:0] step;
        fpcc_word_t rate;
        logic rate_new;
    } fpcc_state_t;
endpackage

// >>> hw/fpcc_top.sv
// Fast pulse counter with compare outputs, compare interrupt and rotation rate, APB slave
// Summary of operation
// R1 - Single compare: output on when count equals low
// R2 - Compare output steered to one of eight points
// R3 - Zone compare: output on while low<=count<=high
// R4 - High below low: code 12h, zone disabled
// R5 - Compare interrupt only with task operation selected
// R6 - Task mode: interrupt each time count equals low
// R7 - Interrupt carries priority level zero to seven
// R8 - Rate = delta times 60000 over pulses times ms
// R9 - Each rate written to destination word
// R10 - Counter inputs not shared with other duties
// R11 - Rate per refresh period; last count updated
// R12 - Ring: wrap to zero with carry, borrow loads set-1
// R13 - Preset source rising edge loads preset value
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fpcc_top #(
    parameter int MS_CYC = fpcc_pkg::MS_CYCLES // Clock cycles per millisecond
) (
    input wire logic pclk, // APB clock, 250 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire logic [7:0] paddr, // APB byte address
    input wire fpcc_pkg::fpcc_word_t pwdata, // APB write data
    output fpcc_pkg::fpcc_word_t prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped address
    input wire logic cnt_pulse_pin, // Count pulse pin
    input wire logic cnt_dir_pin, // Direction pin, high counts down
    input wire logic preset_pin, // External preset pin
    output logic [7:0] out_points, // Discrete compare output points
    output logic cmp_irq, // Compare interrupt request pulse
    output logic [2:0] cmp_irq_prio // Priority of the compare interrupt
);
    import fpcc_pkg::*;

    fpcc_state_t s_q;
    fpcc_state_t s_d;
    logic wr_acc;
    logic pulse_rise;
    logic pre_edge;
    logic ring_act;
    logic zone_err;
    logic eq;
    logic hit;
    logic tick_ms;
    logic tick_ref;
    logic [32:0] diff;
    logic [32:0] diff_abs;
    logic [32:0] rem_t;
    logic [15:0] ref_ms;
    logic [7:0] err_code;
    fpcc_word_t rd;
    fpcc_word_t cnt_inc;
    fpcc_word_t cnt_dec;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Pins pass three flops; edges are taken from the second and third only
        s_d.pulse_sy = {s_q.pulse_sy[1:0], cnt_pulse_pin};
        s_d.dir_sy = {s_q.dir_sy[1:0], cnt_dir_pin};
        s_d.pre_sy = {s_q.pre_sy[1:0], preset_pin};
        pulse_rise = s_q.pulse_sy[1] & ~s_q.pulse_sy[2];

        // APB: zero-wait slave, answer prepared in the setup cycle
        wr_acc = psel & penable & s_q.pready & pwrite;
        zone_err = s_q.high < s_q.low;
        err_code = s_q.ring_err ? (zone_err ? ERR_BOTH : ERR_RING) : (zone_err ? ERR_ZONE : ERR_NONE);
        case (paddr)
            ADDR_CTRL: rd = s_q.ctrl;
            ADDR_RING: rd = s_q.ring_set;
            ADDR_PRESET: rd = s_q.preset;
            ADDR_LOW: rd = s_q.low;
            ADDR_HIGH: rd = s_q.high;
            ADDR_REFRESH: rd = {19'h0, s_q.refresh};
            ADDR_PPR: rd = {16'h0, s_q.ppr};
            ADDR_COUNT: rd = s_q.count;
            ADDR_RATE: rd = s_q.rate;
            ADDR_STATUS: rd = {20'h0, s_q.rate_new, s_q.irq_pend, s_q.borrow, s_q.carry, err_code};
            default: rd = 32'h0000_0000;
        endcase
        s_d.pready = psel & ~penable;
        s_d.prdata = (psel & ~penable & ~pwrite) ? rd : 32'h0000_0000;
        s_d.pslverr = psel & ~penable & ((paddr > ADDR_STATUS) | (paddr[1:0] != 2'b00));
        if (wr_acc) begin
            case (paddr)
                ADDR_CTRL: s_d.ctrl = pwdata;
                ADDR_RING: s_d.ring_set = pwdata;
                ADDR_PRESET: s_d.preset = pwdata;
                ADDR_LOW: s_d.low = pwdata;
                ADDR_HIGH: s_d.high = pwdata;
                ADDR_REFRESH: s_d.refresh = pwdata[12:0];
                ADDR_PPR: s_d.ppr = pwdata[15:0];
                default: ;
            endcase
        end

        // Start command: a rising edge re-evaluates the ring setting, which sets or clears its error
        s_d.start_prev = s_q.ctrl[C_START];
        s_d.running = s_q.ctrl[C_START];
        if (s_q.ctrl[C_START] & ~s_q.start_prev) begin
            s_d.ring_err = s_q.ctrl[C_RING] & ((s_q.ring_set < RING_MIN) | s_q.ring_set[31]);
            s_d.carry = 1'b0;
            s_d.borrow = 1'b0;
        end
        // A faulty ring setting falls back to linear counting
        ring_act = s_q.ctrl[C_RING] & ~s_q.ring_err;

        // Preset source: internal control bit or external pin
        s_d.int_pre_prev = s_q.ctrl[C_INT_PRE];
        pre_edge = s_q.ctrl[C_EXT_PRE] ? (s_q.pre_sy[1] & ~s_q.pre_sy[2])
                                       : (s_q.ctrl[C_INT_PRE] & ~s_q.int_pre_prev);
        cnt_inc = s_q.count + 32'h0000_0001;
        cnt_dec = s_q.count - 32'h0000_0001;
        if (pre_edge) begin
            s_d.count = s_q.preset; // R13
            s_d.carry = 1'b0;
            s_d.borrow = 1'b0;
            if (ring_act & (s_q.preset[31] | (s_q.preset >= s_q.ring_set))) begin
                s_d.ring_err = 1'b1;
            end
        end else if (s_q.running & pulse_rise & ~s_q.dir_sy[1]) begin
            if (ring_act) begin
                if (cnt_inc >= s_q.ring_set) begin
                    s_d.count = 32'h0000_0000; // R12
                    s_d.carry = 1'b1; // R12
                end else begin
                    s_d.count = cnt_inc;
                end
            end else if (~s_q.carry & ~s_q.borrow) begin
                // Linear overflow stops counting until a preset or a rising edge of start
                if (s_q.count == 32'h7FFF_FFFF) begin
                    s_d.carry = 1'b1;
                end else begin
                    s_d.count = cnt_inc;
                end
            end
        end else if (s_q.running & pulse_rise & s_q.dir_sy[1]) begin
            if (ring_act) begin
                if (s_q.count == 32'h0000_0000) begin
                    s_d.count = s_q.ring_set - 32'h0000_0001; // R12
                    s_d.borrow = 1'b1; // R12
                end else begin
                    s_d.count = cnt_dec;
                end
            end else if (~s_q.carry & ~s_q.borrow) begin
                if (s_q.count == 32'h8000_0000) begin
                    s_d.borrow = 1'b1;
                end else begin
                    s_d.count = cnt_dec;
                end
            end
        end

        // Compare stage, signed since the linear range is two's complement
        eq = s_q.count == s_q.low;
        if (s_q.ctrl[C_ZONE]) begin
            hit = ~zone_err & ($signed(s_q.count) >= $signed(s_q.low))
                & ($signed(s_q.count) <= $signed(s_q.high)); // R3 R4
        end else begin
            hit = eq; // R1
        end
        s_d.outs = (s_q.ctrl[C_CMP_EN] & hit) ? (8'h01 << s_q.ctrl[C_POINT +: 3]) : 8'h00; // R2

        // Compare interrupt on entering equality; pending bit is write-one-to-clear, set wins
        s_d.eq_prev = eq;
        s_d.irq = s_q.ctrl[C_TASK] & s_q.running & eq & ~s_q.eq_prev; // R5 R6
        s_d.prio = s_q.ctrl[C_PRIO +: 3]; // R7
        if (wr_acc & (paddr == ADDR_STATUS)) begin
            if (pwdata[S_IRQ]) begin
                s_d.irq_pend = 1'b0;
            end
            if (pwdata[S_RATE_NEW]) begin
                s_d.rate_new = 1'b0;
            end
        end
        if (s_d.irq) begin
            s_d.irq_pend = 1'b1;
        end

        // Millisecond and refresh period timers
        tick_ms = s_q.ms_cnt == 18'(MS_CYC - 1);
        s_d.ms_cnt = tick_ms ? 18'h00000 : s_q.ms_cnt + 18'h00001;
        ref_ms = 16'((s_q.refresh == 13'h0000 ? 13'h0001 : s_q.refresh) * REFRESH_UNIT_MS);
        tick_ref = tick_ms & (s_q.ref_cnt >= ref_ms - 16'h0001);
        if (~s_q.ctrl[C_RATE_EN]) begin
            s_d.ref_cnt = 16'h0000;
        end else if (tick_ms) begin
            s_d.ref_cnt = tick_ref ? 16'h0000 : s_q.ref_cnt + 16'h0001; // R11
        end

        // Rate: sign-magnitude restoring division, one quotient bit per cycle
        diff = {s_q.count[31], s_q.count} - {s_q.last[31], s_q.last};
        diff_abs = diff[32] ? (33'h0 - diff) : diff;
        rem_t = {s_q.rem[31:0], s_q.num[47]};
        case (s_q.rst)
            RS_IDLE: begin
                if (s_q.ctrl[C_RATE_EN] & tick_ref) begin
                    s_d.last = s_q.count; // R11
                    s_d.neg = diff[32];
                    s_d.num = 48'(diff_abs) * RATE_SCALE; // R8
                    s_d.den = 32'(s_q.ppr == 16'h0000 ? 16'h0001 : s_q.ppr) * 32'(ref_ms); // R8
                    s_d.rem = 33'h0;
                    s_d.step = 6'h00;
                    s_d.rst = RS_DIV;
                end
            end
            RS_DIV: begin
                s_d.step = s_q.step + 6'h01;
                if (rem_t >= {1'b0, s_q.den}) begin
                    s_d.rem = rem_t - {1'b0, s_q.den};
                    s_d.num = {s_q.num[46:0], 1'b1};
                end else begin
                    s_d.rem = rem_t;
                    s_d.num = {s_q.num[46:0], 1'b0};
                end
                if (s_q.step == DIV_STEPS - 6'h01) begin
                    s_d.rst = RS_WRITE;
                end
            end
            RS_WRITE: begin
                s_d.rate = s_q.neg ? (32'h0 - s_q.num[31:0]) : s_q.num[31:0]; // R9
                s_d.rate_new = 1'b1;
                s_d.rst = RS_IDLE;
            end
            default: s_d.rst = RS_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RST;
            s_q.ring_set <= RING_RST;
            s_q.refresh <= REFRESH_RST;
            s_q.ppr <= PPR_RST;
            s_q.rst <= RS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from state flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign out_points = s_q.outs;
    assign cmp_irq = s_q.irq;
    assign cmp_irq_prio = s_q.prio;
endmodule
`default_nettype wire

// >>> testbench/fpcc_enc_model.sv
// Encoder and preset contact model facing the counter pins
`timescale 1ns/1ps
`default_nettype none
module fpcc_enc_model (
    output logic pulse, // Count pulse contact
    output logic dir, // Direction contact, high counts down
    output logic preset, // External preset contact
    input wire logic pclk // Clock
);
    // Contacts idle low; each contact serves one duty only
    initial begin
        pulse = 1'b0;
        dir = 1'b0;
        preset = 1'b0;
    end
    // One count; direction set a cycle early, inverted when the pulse falls
    task automatic step(input logic down);
        dir <= down;
        @(posedge pclk);
        pulse <= 1'b1;
        repeat (3) @(posedge pclk);
        pulse <= 1'b0;
        dir <= ~down;
        repeat (3) @(posedge pclk);
    endtask
    // One rising edge on the preset contact
    task automatic preset_pulse();
        preset <= 1'b1;
        repeat (3) @(posedge pclk);
        preset <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// >>> testbench/fpcc_properties.sv
// Port checker of the compare and rate unit
`timescale 1ns/1ps
`default_nettype none
module fpcc_properties (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [7:0] paddr, // Byte address
    input wire fpcc_pkg::fpcc_word_t prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [7:0] out_points, // Compare outputs
    input wire logic cmp_irq, // Interrupt pulse
    input wire logic [2:0] cmp_irq_prio // Priority
);
    import fpcc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence bad_setup_s;
        psel && !penable && (paddr > ADDR_STATUS || paddr[1:0] != 2'b00);
    endsequence
    sequence ctrl_wr_s;
        psel && penable && pwrite;
    endsequence
    // No wait states, answer only in the access cycle
    chk_ready_after_setup: assert property (setup_s |=> pready && penable)
        else $error("ready missing after setup");
    chk_ready_in_access: assert property (pready |-> penable && $past(psel && !penable))
        else $error("ready outside access");
    chk_err_unmapped: assert property (bad_setup_s |=> pready && pslverr && prdata == '0)
        else $error("unmapped access not refused");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_write_ready: assert property (ctrl_wr_s |-> pready)
        else $error("write access without ready");
    chk_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("read data outside access");
    // Compare outputs and interrupt
    chk_out_onehot: assert property ($onehot0(out_points))
        else $error("more than one output point on");
    chk_out_moves: assert property (
        ($past(out_points) != 8'h00 && out_points != 8'h00 && out_points != $past(out_points))
        |-> ($past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2)))
        else $error("output point moved without a write");
    chk_irq_pulse: assert property (cmp_irq |=> !cmp_irq)
        else $error("interrupt longer than one cycle");
    chk_prio_from_write: assert property ($changed(cmp_irq_prio) |->
        ($past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2)))
        else $error("priority changed without a write");
endmodule
bind fpcc_top fpcc_properties i_fpcc_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .out_points(out_points), .cmp_irq(cmp_irq), .cmp_irq_prio(cmp_irq_prio));
`default_nettype wire

// >>> testbench/test_counter_compare_and_rpm_unit.sv
// Self-checking bench of the compare and rate unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module test_counter_compare_and_rpm_unit;
    import fpcc_pkg::*;
    localparam fpcc_word_t c_st = 32'h0000_0001 << C_START;
    localparam fpcc_word_t c_cmp = 32'h0000_0001 << C_CMP_EN;
    localparam fpcc_word_t c_zone = 32'h0000_0001 << C_ZONE;
    localparam fpcc_word_t c_task = 32'h0000_0001 << C_TASK;
    localparam fpcc_word_t c_rate = 32'h0000_0001 << C_RATE_EN;
    localparam fpcc_word_t c_ext = 32'h0000_0001 << C_EXT_PRE;
    localparam fpcc_word_t c_ring = 32'h0000_0001 << C_RING;
    localparam fpcc_word_t c_ipre = 32'h0000_0001 << C_INT_PRE;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmp_irq, pulse, dir, pre;
    logic [7:0] paddr, out_points;
    logic [2:0] cmp_irq_prio, pr;
    fpcc_word_t pwdata, prdata, rv;
    logic [32:0] exp_q[$];
    logic [31:0] seed = 32'h0000_004B;
    int num_errors = 0, checked = 0, irq_n = 0, base, ppr;
    fpcc_top #(.MS_CYC(10)) i_fpcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cnt_pulse_pin(pulse), .cnt_dir_pin(dir), .preset_pin(pre),
        .out_points(out_points), .cmp_irq(cmp_irq), .cmp_irq_prio(cmp_irq_prio));
    fpcc_enc_model i_fpcc_enc_model (.pulse(pulse), .dir(dir), .preset(pre), .pclk(pclk));
    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // One APB transfer; the edge after it passes so signals never toggle twice at once
    task automatic xfer(input logic w, input logic [7:0] a, input fpcc_word_t wd, input logic [32:0] e,
        output fpcc_word_t r);
        int n;
        n = 0;
        if (!w) exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) num_errors++;
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle bus carries junk so that nothing leans on a quiet address or data
        paddr <= 8'(xs());
        pwdata <= xs();
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input fpcc_word_t d);
        fpcc_word_t r;
        xfer(1'b1, a, d, '0, r);
    endtask
    task automatic rd(input logic [7:0] a, input fpcc_word_t e);
        fpcc_word_t r;
        xfer(1'b0, a, '0, {1'b1, e}, r);
    endtask
    // Poll for a new rate, then clear its flag
    task automatic wait_rate();
        fpcc_word_t r;
        int n;
        n = 0;
        r = '0;
        while (r[S_RATE_NEW] !== 1'b1 && n < 300) begin
            xfer(1'b0, ADDR_STATUS, '0, '0, r);
            n++;
        end
        `CHK("rate flag", 1'b1, r[S_RATE_NEW])
        wr(ADDR_STATUS, 32'h0000_0800);
    endtask
    task automatic chk_out(input logic [7:0] e);
        repeat (6) @(posedge pclk);
        `CHK("out_points", e, out_points)
    endtask
    // Read results are compared against the oldest note
    always @(posedge pclk) begin
        logic [32:0] e;
        if (presetn && psel && penable && pready === 1'b1) begin
            `CHK("pslverr", paddr > ADDR_STATUS, pslverr)
            if (!pwrite) begin
                e = exp_q.pop_front();
                if (e[32]) `CHK("prdata", e[31:0], prdata)
            end
        end
    end
    always @(posedge pclk) if (cmp_irq === 1'b1) irq_n <= irq_n + 1;
    task automatic end_of_test();
        if (num_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'(xs());
        pwdata = xs();
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_RING, RING_RST);
        rd(ADDR_REFRESH, 32'(REFRESH_RST));
        rd(ADDR_PPR, 32'(PPR_RST));
        rd(8'h28, 32'h0000_0000);
        wr(ADDR_COUNT, xs());
        rd(ADDR_COUNT, 32'h0000_0000);
        wr(ADDR_LOW, 32'h0000_0005);
        wr(ADDR_HIGH, 32'h0000_0003);
        rd(ADDR_STATUS, 32'(ERR_ZONE));
        wr(ADDR_HIGH, 32'h0000_0007);
        rd(ADDR_STATUS, 32'h0000_0000);
        wr(ADDR_REFRESH, 32'h0000_0002);
        wr(ADDR_PRESET, 32'h0000_0005);
        wr(ADDR_CTRL, c_st | c_ext);
        i_fpcc_enc_model.preset_pulse();
        rd(ADDR_COUNT, 32'h0000_0005);
        // Count sits on the low value; steer the output over all eight points
        for (int p = 0; p < 8; p++) begin
            wr(ADDR_CTRL, c_st | c_ext | c_cmp | (p << C_POINT));
            chk_out(8'h01 << p);
        end
        // Zone window 5..7 walked upward to 8
        wr(ADDR_CTRL, c_st | c_cmp | c_zone | (3 << C_POINT));
        for (int k = 0; k < 4; k++) begin
            chk_out(k < 3 ? 8'h08 : 8'h00);
            i_fpcc_enc_model.step(1'b0);
        end
        // Task mode: count down from 9 onto the low value
        rv = xs();
        pr = rv[2:0];
        base = irq_n;
        wr(ADDR_CTRL, c_st | c_task | (pr << C_PRIO));
        repeat (4) i_fpcc_enc_model.step(1'b1);
        chk_out(8'h00);
        `CHK("irq count", base + 1, irq_n)
        `CHK("prio", pr, cmp_irq_prio)
        rd(ADDR_STATUS, 32'h0000_0400);
        wr(ADDR_STATUS, 32'h0000_0400);
        rd(ADDR_STATUS, 32'h0000_0000);
        wr(ADDR_CTRL, c_st);
        i_fpcc_enc_model.step(1'b1);
        i_fpcc_enc_model.step(1'b0);
        `CHK("irq count", base + 1, irq_n)
        // Rate over a 20 ms period with five counts
        rv = xs();
        ppr = rv[3:0] + 1;
        wr(ADDR_PPR, 32'(ppr));
        wr(ADDR_CTRL, c_st | c_rate);
        wait_rate();
        repeat (5) i_fpcc_enc_model.step(1'b0);
        wait_rate();
        rd(ADDR_RATE, 32'(5 * 60000 / (ppr * 20)));
        wait_rate();
        rd(ADDR_RATE, 32'h0000_0000);
        // Ring of three: internal preset to 1, wrap upward, then borrow back
        wr(ADDR_CTRL, 32'h0000_0000);
        wr(ADDR_RING, 32'h0000_0003);
        wr(ADDR_PRESET, 32'h0000_0001);
        wr(ADDR_CTRL, c_ring | c_ipre);
        wr(ADDR_CTRL, c_st | c_ring);
        rd(ADDR_COUNT, 32'h0000_0001);
        repeat (2) i_fpcc_enc_model.step(1'b0);
        rd(ADDR_COUNT, 32'h0000_0000);
        i_fpcc_enc_model.step(1'b1);
        rd(ADDR_COUNT, 32'h0000_0002);
        rd(ADDR_STATUS, 32'h0000_0300);
        // Mid-run reset brings settings and count back to their reset values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_RING, RING_RST);
        rd(ADDR_COUNT, 32'h0000_0000);
        end_of_test();
    end
endmodule
`default_nettype wire
